// ===== hw/ptr_result_regs.sv
// Purpose: result registers for pressure and temperature, read byte-wise by the serial master
// Assumes: conversion results arrive as one-cycle strobes; txn_active is high for a whole bus transfer
// Notes: results arriving during a transfer wait in a pending slot until the transfer ends
//
// Summary of operation
// R1: each pressure result is one 24-bit two's-complement value readable as a whole.
// R2: pressure bits 7..0 sit at 28h, 15..8 at 29h and 23..16 at 2Ah.
// R3: the pressure reported is the measured pressure minus the offset reference.
// R4: pressure is 1/4096 hPa per count with full-scale select 0 and 1/2048 hPa with it set.
// R5: temperature is a 16-bit value with its low byte at 2Bh and high byte at 2Ch.
// R6: temperature is two's complement so sub-zero values are negative counts.
// R7: one temperature count is 0.01 degree Celsius.
// R8: writes never alter the three pressure result bytes.
// R9: writes never alter the two temperature result bytes.
// R10: with auto-increment on the subaddress advances after each byte.
// R11: a new pressure result sets the available flag, and overwriting an unread one sets overrun; replacing a pending one as it commits does not.
// R12: a new temperature result sets its available flag, and overwriting an unread one sets overrun; replacing a pending one as it commits does not.
// R13: all bytes of one result stay stable during a multi-byte read.
`timescale 1ns/1ns
module ptr_result_regs
  import ptr_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic addr_load,
  input wire logic [7:0] addr_in,
  input wire logic rd_req,
  input wire logic wr_req,
  input wire logic [7:0] wr_data,
  input wire logic txn_active,
  input wire logic auto_inc,
  input wire logic full_scale_select,
  input wire logic [15:0] pressure_offset_reference,
  input wire logic [23:0] p_raw,
  input wire logic p_raw_valid,
  input wire logic [15:0] t_raw,
  input wire logic t_raw_valid,
  output logic [7:0] rd_data_r,
  output logic rd_valid_r,
  output logic [7:0] sub_addr_r,
  output logic pressure_new_flag_r,
  output logic pressure_overrun_r,
  output logic temperature_new_flag_r,
  output logic temperature_overrun_r
);

  // ----------------------------------------
  // pressure arithmetic
  // ----------------------------------------
  logic signed [23:0] p_diff;
  logic signed [23:0] p_calc;
  // raw counts are 1/4096 hPa; offset is sign-extended into the same units
  assign p_diff = $signed(p_raw) - $signed({{8{pressure_offset_reference[15]}}, pressure_offset_reference}); // R3
  assign p_calc = full_scale_select ? (p_diff >>> 1) : p_diff; // R4 R1

  // ----------------------------------------
  // result and pending state
  // ----------------------------------------
  logic [23:0] pressure_result_bits_r, pressure_result_bits_nxt;
  logic [15:0] temperature_result_bits_r, temperature_result_bits_nxt;
  logic [23:0] p_pend_r, p_pend_nxt;
  logic [15:0] t_pend_r, t_pend_nxt;
  logic p_pend_v_r, p_pend_v_nxt;
  logic t_pend_v_r, t_pend_v_nxt;
  logic p_commit, t_commit;
  logic [23:0] p_src;
  logic [15:0] t_src;

  // commit only between transfers so a burst never mixes two conversions
  assign p_commit = !txn_active && (p_raw_valid || p_pend_v_r); // R13
  assign t_commit = !txn_active && (t_raw_valid || t_pend_v_r); // R13
  assign p_src = p_raw_valid ? p_calc : p_pend_r;
  assign t_src = t_raw_valid ? t_raw : t_pend_r; // R6 R7

  always_comb begin
    pressure_result_bits_nxt = pressure_result_bits_r;
    temperature_result_bits_nxt = temperature_result_bits_r;
    p_pend_nxt = p_pend_r;
    t_pend_nxt = t_pend_r;
    p_pend_v_nxt = p_pend_v_r;
    t_pend_v_nxt = t_pend_v_r;
    // bus writes have no path into the result registers
    if (p_commit) begin
      pressure_result_bits_nxt = p_src; // R8
      p_pend_v_nxt = 1'b0;
    end else if (p_raw_valid) begin
      p_pend_nxt = p_calc;
      p_pend_v_nxt = 1'b1;
    end
    if (t_commit) begin
      temperature_result_bits_nxt = t_src; // R9
      t_pend_v_nxt = 1'b0;
    end else if (t_raw_valid) begin
      t_pend_nxt = t_raw;
      t_pend_v_nxt = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      pressure_result_bits_r <= PTR_P_RESET;
      temperature_result_bits_r <= PTR_T_RESET;
      p_pend_r <= PTR_P_RESET;
      t_pend_r <= PTR_T_RESET;
      p_pend_v_r <= 1'b0;
      t_pend_v_r <= 1'b0;
    end else begin
      pressure_result_bits_r <= pressure_result_bits_nxt;
      temperature_result_bits_r <= temperature_result_bits_nxt;
      p_pend_r <= p_pend_nxt;
      t_pend_r <= t_pend_nxt;
      p_pend_v_r <= p_pend_v_nxt;
      t_pend_v_r <= t_pend_v_nxt;
    end
  end

  // ----------------------------------------
  // status flags
  // ----------------------------------------
  ptr_flags_s p_flags_nxt, t_flags_nxt;
  logic p_rd_clr, t_rd_clr;
  // reading the top byte marks the result as taken
  assign p_rd_clr = rd_req && (sub_addr_r == PTR_SUB_P_HIGH);
  assign t_rd_clr = rd_req && (sub_addr_r == PTR_SUB_T_HIGH);

  always_comb begin
    p_flags_nxt.new_flag = pressure_new_flag_r;
    p_flags_nxt.overrun = pressure_overrun_r;
    t_flags_nxt.new_flag = temperature_new_flag_r;
    t_flags_nxt.overrun = temperature_overrun_r;
    if (p_rd_clr) begin
      p_flags_nxt = '{new_flag: 1'b0, overrun: 1'b0};
    end
    if (t_rd_clr) begin
      t_flags_nxt = '{new_flag: 1'b0, overrun: 1'b0};
    end
    // set after clear so a same-cycle event is never lost
    if (p_commit) begin
      p_flags_nxt.new_flag = 1'b1; // R11
      if (pressure_new_flag_r) begin
        p_flags_nxt.overrun = 1'b1; // R11
      end
    end
    if (p_raw_valid && p_pend_v_r && !p_commit) begin
      p_flags_nxt.overrun = 1'b1; // R11
    end
    if (t_commit) begin
      t_flags_nxt.new_flag = 1'b1; // R12
      if (temperature_new_flag_r) begin
        t_flags_nxt.overrun = 1'b1; // R12
      end
    end
    if (t_raw_valid && t_pend_v_r && !t_commit) begin
      t_flags_nxt.overrun = 1'b1; // R12
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      pressure_new_flag_r <= 1'b0;
      pressure_overrun_r <= 1'b0;
      temperature_new_flag_r <= 1'b0;
      temperature_overrun_r <= 1'b0;
    end else begin
      pressure_new_flag_r <= p_flags_nxt.new_flag;
      pressure_overrun_r <= p_flags_nxt.overrun;
      temperature_new_flag_r <= t_flags_nxt.new_flag;
      temperature_overrun_r <= t_flags_nxt.overrun;
    end
  end

  // ----------------------------------------
  // register port
  // ----------------------------------------
  logic [7:0] sub_addr_nxt, rd_data_nxt;
  logic rd_valid_nxt;

  always_comb begin
    sub_addr_nxt = sub_addr_r;
    rd_data_nxt = rd_data_r;
    rd_valid_nxt = rd_req;
    if (rd_req) begin
      case (sub_addr_r)
        PTR_SUB_STATUS: begin
          rd_data_nxt = 8'h00;
          rd_data_nxt[PTR_BIT_P_NEW] = pressure_new_flag_r;
          rd_data_nxt[PTR_BIT_T_NEW] = temperature_new_flag_r;
          rd_data_nxt[PTR_BIT_P_OVR] = pressure_overrun_r;
          rd_data_nxt[PTR_BIT_T_OVR] = temperature_overrun_r;
        end
        PTR_SUB_P_LOW: rd_data_nxt = pressure_result_bits_r[7:0]; // R2
        PTR_SUB_P_MID: rd_data_nxt = pressure_result_bits_r[15:8]; // R2
        PTR_SUB_P_HIGH: rd_data_nxt = pressure_result_bits_r[23:16]; // R2
        PTR_SUB_T_LOW: rd_data_nxt = temperature_result_bits_r[7:0]; // R5
        PTR_SUB_T_HIGH: rd_data_nxt = temperature_result_bits_r[15:8]; // R5
        default: rd_data_nxt = 8'h00;
      endcase
    end
    if (addr_load) begin
      sub_addr_nxt = addr_in;
    end else if ((rd_req || wr_req) && auto_inc) begin
      sub_addr_nxt = sub_addr_r + 8'h01; // R10
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      sub_addr_r <= PTR_SUB_RESET;
      rd_data_r <= PTR_RD_RESET;
      rd_valid_r <= 1'b0;
    end else begin
      sub_addr_r <= sub_addr_nxt;
      rd_data_r <= rd_data_nxt;
      rd_valid_r <= rd_valid_nxt;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  property p_pres_result;
    @(posedge mclk) disable iff (reset)
    (p_commit && p_raw_valid) |=> (pressure_result_bits_r == $past(p_calc));
  endproperty
  a_pres_result: assert property (p_pres_result) else $error("pressure result not offset and scaled"); // R3

  property p_fs_half;
    @(posedge mclk) disable iff (reset)
    (p_commit && p_raw_valid && full_scale_select && p_pend_v_r == 1'b0)
      |=> (pressure_result_bits_r[23] == $past(p_diff[23]));
  endproperty
  a_fs_half: assert property (p_fs_half) else $error("half scale lost sign"); // R4

  property p_rd_p_high;
    @(posedge mclk) disable iff (reset)
    (rd_req && sub_addr_r == PTR_SUB_P_HIGH && !p_commit)
      |=> rd_valid_r && (rd_data_r == pressure_result_bits_r[23:16]);
  endproperty
  a_rd_p_high: assert property (p_rd_p_high) else $error("pressure high byte misplaced"); // R2

  property p_rd_t_low;
    @(posedge mclk) disable iff (reset)
    (rd_req && sub_addr_r == PTR_SUB_T_LOW && !t_commit)
      |=> (rd_data_r == temperature_result_bits_r[7:0]);
  endproperty
  a_rd_t_low: assert property (p_rd_t_low) else $error("temperature low byte misplaced"); // R5

  property p_t_pass;
    @(posedge mclk) disable iff (reset)
    (t_commit && t_raw_valid) |=> (temperature_result_bits_r == $past(t_raw));
  endproperty
  a_t_pass: assert property (p_t_pass) else $error("temperature altered"); // R6

  property p_wr_keep;
    @(posedge mclk) disable iff (reset)
    (wr_req && !p_commit && !t_commit)
      |=> $stable(pressure_result_bits_r) && $stable(temperature_result_bits_r);
  endproperty
  a_wr_keep: assert property (p_wr_keep) else $error("write changed a result"); // R8

  property p_inc;
    @(posedge mclk) disable iff (reset)
    (rd_req && auto_inc && !addr_load) |=> (sub_addr_r == $past(sub_addr_r) + 8'h01);
  endproperty
  a_inc: assert property (p_inc) else $error("subaddress did not advance"); // R10

  property p_no_inc;
    @(posedge mclk) disable iff (reset)
    (rd_req && !auto_inc && !addr_load) |=> $stable(sub_addr_r);
  endproperty
  a_no_inc: assert property (p_no_inc) else $error("subaddress moved with increment off"); // R10

  property p_p_ovr;
    @(posedge mclk) disable iff (reset)
    (p_commit && pressure_new_flag_r) |=> pressure_overrun_r && pressure_new_flag_r;
  endproperty
  a_p_ovr: assert property (p_p_ovr) else $error("pressure overrun missed"); // R11

  property p_t_new;
    @(posedge mclk) disable iff (reset)
    t_commit |=> temperature_new_flag_r;
  endproperty
  a_t_new: assert property (p_t_new) else $error("temperature flag not set"); // R12

  property p_hold;
    @(posedge mclk) disable iff (reset)
    (txn_active && $past(txn_active)) |=> $stable(pressure_result_bits_r) && $stable(temperature_result_bits_r);
  endproperty
  a_hold: assert property (p_hold) else $error("result changed during transfer"); // R13

endmodule : ptr_result_regs

// ===== hw/ptr_pkg.sv
// Purpose: shared constants and types for the pressure/temperature result registers
// Assumes: byte-wide register port driven by the serial slave front end
// Notes: subaddresses are the device's own register map
package ptr_pkg;
  localparam logic [7:0] PTR_SUB_STATUS = 8'h27;
  localparam logic [7:0] PTR_SUB_P_LOW = 8'h28;
  localparam logic [7:0] PTR_SUB_P_MID = 8'h29;
  localparam logic [7:0] PTR_SUB_P_HIGH = 8'h2A;
  localparam logic [7:0] PTR_SUB_T_LOW = 8'h2B;
  localparam logic [7:0] PTR_SUB_T_HIGH = 8'h2C;
  localparam logic [7:0] PTR_SUB_RESET = 8'h00;
  localparam logic [23:0] PTR_P_RESET = 24'h000000;
  localparam logic [15:0] PTR_T_RESET = 16'h0000;
  localparam logic [7:0] PTR_RD_RESET = 8'h00;
  localparam int PTR_BIT_P_NEW = 0;
  localparam int PTR_BIT_T_NEW = 1;
  localparam int PTR_BIT_P_OVR = 4;
  localparam int PTR_BIT_T_OVR = 5;

  typedef struct packed {
    logic new_flag;
    logic overrun;
  } ptr_flags_s;
endpackage : ptr_pkg

// ===== verification/ptr_master_model.sv
// Purpose: serial master side of the result register port
// Assumes: one request per cycle, read byte one cycle after rd_req
// Notes: released addr_in and wr_data go to their inverse so stale values never look live
`timescale 1ns/1ns
module ptr_master_model
  import ptr_pkg::*;
(
  input wire logic mclk,
  input wire logic [7:0] rd_data_r,
  input wire logic rd_valid_r,
  output logic addr_load,
  output logic [7:0] addr_in,
  output logic rd_req,
  output logic wr_req,
  output logic [7:0] wr_data,
  output logic txn_active
);
  logic [8:0] got [0:7];
  initial begin
    addr_load = 1'b0;
    addr_in = 8'h00;
    rd_req = 1'b0;
    wr_req = 1'b0;
    wr_data = 8'h00;
    txn_active = 1'b0;
  end
  // -----------------------------
  // transfer steps
  // -----------------------------
  task start(input logic [7:0] a);
    @(posedge mclk);
    txn_active <= 1'b1;
    addr_load <= 1'b1;
    addr_in <= a;
    @(posedge mclk);
    addr_load <= 1'b0;
    addr_in <= ~a;
  endtask : start
  // one subaddress, then back-to-back reads ride the increment
  task burst(input logic [7:0] a, input int n);
    start(a);
    rd_req <= 1'b1;
    for (int i = 0; i <= n; i++) begin
      @(posedge mclk);
      if (i > 0) got[i-1] = {rd_valid_r, rd_data_r};
      if (i == n - 1) rd_req <= 1'b0;
    end
    txn_active <= 1'b0;
  endtask : burst
  task write(input logic [7:0] a, input logic [7:0] d);
    start(a);
    wr_req <= 1'b1;
    wr_data <= d;
    @(posedge mclk);
    wr_req <= 1'b0;
    wr_data <= ~d;
    txn_active <= 1'b0;
  endtask : write
endmodule : ptr_master_model

// ===== verification/ptr_result_regs_tb.sv
// Purpose: self-checking bench for the result registers
// Assumes: auto-increment at its default of 1 except in one test
// Notes: expected results are worked out here from raw inputs
`timescale 1ns/1ns
module ptr_result_regs_tb
  import ptr_pkg::*;
;
  logic mclk, reset, addr_load, rd_req, wr_req, txn_active, auto_inc, fs, pv, tv, rd_valid_r;
  logic pn, po, tn, to;
  logic [7:0] addr_in, wr_data, rd_data_r, sub_addr_r;
  logic [15:0] off, t_raw;
  logic [23:0] p_raw;
  int n_errors = 0;
  int total_checks = 0;
  ptr_result_regs u_dut (.mclk(mclk), .reset(reset), .addr_load(addr_load), .addr_in(addr_in), .rd_req(rd_req),
    .wr_req(wr_req), .wr_data(wr_data), .txn_active(txn_active), .auto_inc(auto_inc), .full_scale_select(fs),
    .pressure_offset_reference(off), .p_raw(p_raw), .p_raw_valid(pv), .t_raw(t_raw), .t_raw_valid(tv),
    .rd_data_r(rd_data_r), .rd_valid_r(rd_valid_r), .sub_addr_r(sub_addr_r), .pressure_new_flag_r(pn),
    .pressure_overrun_r(po), .temperature_new_flag_r(tn), .temperature_overrun_r(to));
  ptr_master_model u_master (.mclk(mclk), .rd_data_r(rd_data_r), .rd_valid_r(rd_valid_r), .addr_load(addr_load),
    .addr_in(addr_in), .rd_req(rd_req), .wr_req(wr_req), .wr_data(wr_data), .txn_active(txn_active));
  // -----------------------------
  // helpers
  // -----------------------------
  function automatic logic [23:0] pexp(logic [23:0] p, logic [15:0] o, logic s);
    logic signed [23:0] d;
    d = $signed(p) - $signed({{8{o[15]}}, o});
    return s ? d >>> 1 : d;
  endfunction : pexp
  task tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : tally_and_finish
  task check_byte(input string nm, input logic [8:0] e, input logic [8:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : check_byte
  task check_flag(input string nm, input logic e, input logic g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %b seen %b", nm, e, g);
    end
  endtask : check_flag
  task rd_check(input logic [7:0] a, input int n, input logic [63:0] v);
    u_master.burst(a, n);
    for (int i = 0; i < n; i++) check_byte("read byte", {1'b1, v[8*i+:8]}, u_master.got[i]);
  endtask : rd_check
  task conv(input logic pp, input logic tt);
    @(posedge mclk);
    pv <= pp;
    tv <= tt;
    @(posedge mclk);
    pv <= 1'b0;
    tv <= 1'b0;
    @(posedge mclk);
  endtask : conv
  // -----------------------------
  // clock, watchdog, tests
  // -----------------------------
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  initial begin
    repeat (5000) @(posedge mclk);
    n_errors++;
    $display("wrong value watchdog expected done seen hang");
    tally_and_finish();
  end
  initial begin
    reset = 1'b1;
    auto_inc = 1'b1;
    fs = 1'b0;
    off = 16'h0456;
    p_raw = 24'h123456;
    t_raw = 16'hFF38;
    pv = 1'b0;
    tv = 1'b0;
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    conv(1'b1, 1'b0);
    check_flag("p new", 1'b1, pn);
    rd_check(8'h28, 3, pexp(24'h123456, 16'h0456, 1'b0));
    check_byte("sub addr", 9'h12B, {1'b1, sub_addr_r});
    check_flag("p new cleared", 1'b0, pn);
    $display("test offset done");
    fs <= 1'b1;
    off <= 16'h0010;
    p_raw <= 24'hFFF000;
    conv(1'b1, 1'b1);
    check_flag("t new", 1'b1, tn);
    // -2.00 C is FF38 in hundredths
    rd_check(8'h27, 6, {16'hFF38, pexp(24'hFFF000, 16'h0010, 1'b1), 8'h03});
    $display("test burst done");
    conv(1'b1, 1'b1);
    conv(1'b1, 1'b1);
    check_flag("p overrun", 1'b1, po);
    check_flag("t overrun", 1'b1, to);
    rd_check(8'h27, 1, 64'h33);
    $display("test overrun done");
    // increment off: the same byte comes back twice
    auto_inc <= 1'b0;
    rd_check(8'h28, 2, 64'hF8F8);
    check_byte("sub addr fixed", 9'h128, {1'b1, sub_addr_r});
    auto_inc <= 1'b1;
    $display("test no increment done");
    u_master.write(8'h28, 8'hFF);
    u_master.write(8'h2C, 8'h00);
    rd_check(8'h28, 5, {16'hFF38, pexp(24'hFFF000, 16'h0010, 1'b1)});
    $display("test read only done");
    // new result lands mid-burst and must wait for the transfer end
    fork
      rd_check(8'h28, 3, pexp(24'hFFF000, 16'h0010, 1'b1));
      begin
        repeat (3) @(posedge mclk);
        p_raw <= 24'h000100;
        t_raw <= 16'h09C4;
        pv <= 1'b1;
        tv <= 1'b1;
        // second strobe replaces the pending value and flags overrun
        repeat (2) @(posedge mclk);
        pv <= 1'b0;
        tv <= 1'b0;
      end
    join
    repeat (2) @(posedge mclk);
    check_flag("p overrun pending", 1'b1, po);
    check_flag("t overrun pending", 1'b1, to);
    rd_check(8'h28, 5, {16'h09C4, pexp(24'h000100, 16'h0010, 1'b1)});
    $display("test stable read done");
    tally_and_finish();
  end
endmodule : ptr_result_regs_tb
